// File: src/usp_serial_port.sv
// Serial port block: two asynchronous engines, rate logic and register port
//
// Contract
// - Fixed nine-bit mode runs clk/64, or clk/32
// - Shift mode clock clk/12, or clk/2
// - Mode field selects shift, UART8, UART9F, UART9V
// - Variable modes: bit rate is timer tick/16
// - Eight-bit, check set: need stop one
// - Nine-bit, check set: need ninth bit one
// - Reserved mode bits read zero, ignore writes
// - Address compare under mask; broadcast is OR
// - Second port: two modes, no errors, no match
// - Ten-bit frame: start, eight LSB-first, stop
// - Transmit starts at next divide-by-16 rollover
// - Transmit-done rises as stop bit starts
// - Receive only when enabled; falling edge starts
// - Sixteen samples per bit; edge resets counter
// - Vote bit from states seven, eight, nine
// - Start bit voted one: drop, rewait edge
// - Ten-bit load needs done clear, check rule
// - Eleven-bit frame adds programmable ninth bit
// - Buffer write copies ninth bit into shifter
// - Nine-bit: store ninth and data, stop gates done
// - Done flags: hardware sets, software clears zero
`timescale 1ns/1ps

// One asynchronous engine: transmitter and receiver on a 16x tick
module usp_engine
   import usp_pkg::*;
(
   input  wire logic       clk,        // System clock
   input  wire logic       rst,        // Asynchronous reset
   input  wire logic       tick16,     // 16x bit-rate tick
   input  wire logic       active,     // Engine in an asynchronous mode
   input  wire logic       nineBit,    // Eleven-bit frames
   input  wire logic       checkBit,   // multiproc_check
   input  wire logic       useAddr,    // Hardware address recognition
   input  wire logic       rxEnable,   // Receive enable
   input  wire logic       rxdSync,    // Synchronised serial input
   input  wire logic       riFlag,     // Current receive_done_flag
   input  wire logic [7:0] addrVal,    // slave_address
   input  wire logic [7:0] addrMask,   // slave_address_mask
   input  wire logic       txLoad,     // Buffer write pulse
   input  wire logic [7:0] txData,     // Byte to send
   input  wire logic       txNinth,    // transmit_ninth_bit
   output logic            txd,        // Serial output
   output logic            txDoneSet,  // Stop bit starting, pulse
   output logic            rxLoad,     // Frame stored, pulse
   output logic            rxDoneSet,  // Receive-done set, pulse
   output logic [7:0]      rxData,     // Received byte
   output logic            rxNinth     // Ninth or stop bit of accepted frame
);
   import usp_pkg::*;

   // Two out of three vote
   function automatic logic vote3(input logic a, input logic b, input logic c);
      vote3 = (a & b) | (a & c) | (b & c);
   endfunction

   logic          txBusy_reg;
   logic [3:0]    txDiv_reg;
   logic [3:0]    txIdx_reg;
   logic [10:0]   txShift_reg;
   usp_rx_state_t rxState_reg;
   logic [3:0]    rxCnt_reg;
   logic [3:0]    rxIdx_reg;
   logic [1:0]    rxSamp_reg;
   logic [7:0]    rxShift_reg;
   logic          rxNine_reg;
   logic          rxPrev_reg;

   // Transmit bit timing locked to the free divide-by-16 counter
   wire        txRoll    = tick16 && (txDiv_reg == LAST_STATE);
   wire [3:0]  lastBit   = nineBit ? LAST_BIT11 : LAST_BIT10;
   wire        txStart   = txLoad && active && !txBusy_reg;
   wire        ninthOut  = nineBit ? txNinth : 1'b1;
   wire [10:0] txFrame   = {1'b1, ninthOut, txData, 1'b0};
   wire        txEnd     = txIdx_reg == lastBit + 4'h1;

   // Divider free-runs so a write never shortens the first bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txDiv_reg <= 4'h0;
      end else if (tick16) begin
         txDiv_reg <= txDiv_reg + 4'h1;
      end
   end

   // Transmit shifter; a write while busy is dropped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txBusy_reg  <= 1'b0;
         txIdx_reg   <= 4'h0;
         txShift_reg <= 11'h7ff;
         txd         <= 1'b1;
         txDoneSet   <= 1'b0;
      end else begin
         txDoneSet <= 1'b0;
         if (txStart) begin
            txBusy_reg  <= 1'b1;
            txIdx_reg   <= 4'h0;
            txShift_reg <= txFrame;
         end else if (txBusy_reg && txRoll) begin
            if (txEnd) begin
               txBusy_reg <= 1'b0;
            end else begin
               txd         <= txShift_reg[0];
               txShift_reg <= {1'b1, txShift_reg[10:1]};
               txIdx_reg   <= txIdx_reg + 4'h1;
               txDoneSet   <= (txIdx_reg == lastBit);
            end
         end
      end
   end

   // Receive qualification and address recognition
   wire       falling   = rxPrev_reg && !rxdSync;
   wire       sampleNow = tick16 && (rxCnt_reg == SAMPLE_C);
   wire       bitVal    = vote3(rxSamp_reg[0], rxSamp_reg[1], rxdSync);
   wire [7:0] bcast     = addrVal | addrMask;
   wire       addrHit   = ((rxShift_reg ^ addrVal) & addrMask) == 8'h00;
   wire       bcastHit  = (rxShift_reg & bcast) == bcast;
   wire       addrOk    = !useAddr || addrHit || bcastHit;
   wire       accept9   = !riFlag && (!checkBit || (rxNine_reg && addrOk
                          && bitVal));
   // Nine-bit frames with check clear store even with a bad stop bit, but flag nothing
   wire       doneOk    = !nineBit || bitVal;
   wire       accept8   = !riFlag && (!checkBit || bitVal);
   wire       accept    = nineBit ? accept9 : accept8;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxPrev_reg <= 1'b1;
      end else begin
         rxPrev_reg <= rxdSync;
      end
   end

   // Receiver: edge align, three samples, shift, qualify at stop bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxState_reg <= USP_RX_IDLE;
         rxCnt_reg   <= 4'h0;
         rxIdx_reg   <= 4'h0;
         rxSamp_reg  <= 2'h0;
         rxShift_reg <= RESET_BYTE;
         rxNine_reg  <= 1'b0;
         rxLoad      <= 1'b0;
         rxDoneSet   <= 1'b0;
         rxData      <= RESET_BYTE;
         rxNinth     <= 1'b0;
      end else begin
         rxLoad    <= 1'b0;
         rxDoneSet <= 1'b0;
         case (rxState_reg)
            USP_RX_IDLE: begin
               if (rxEnable && active && falling) begin
                  rxState_reg <= USP_RX_BUSY;
                  rxCnt_reg   <= 4'h0;
                  rxIdx_reg   <= 4'h0;
               end
            end
            USP_RX_BUSY: begin
               if (!rxEnable || !active) begin
                  rxState_reg <= USP_RX_IDLE;
               end else if (tick16) begin
                  rxCnt_reg <= rxCnt_reg + 4'h1;
                  if (rxCnt_reg == SAMPLE_A) begin
                     rxSamp_reg[0] <= rxdSync;
                  end
                  if (rxCnt_reg == SAMPLE_B) begin
                     rxSamp_reg[1] <= rxdSync;
                  end
                  if (sampleNow) begin
                     rxIdx_reg <= rxIdx_reg + 4'h1;
                     if (rxIdx_reg == 4'h0 && bitVal) begin
                        rxState_reg <= USP_RX_IDLE;
                     end else if (rxIdx_reg == lastBit) begin
                        rxState_reg <= USP_RX_IDLE;
                        if (accept) begin
                           rxLoad  <= 1'b1;
                           rxDoneSet <= doneOk;
                           rxData  <= rxShift_reg;
                           rxNinth <= nineBit ? rxNine_reg : bitVal;
                        end
                     end else if (rxIdx_reg == LAST_BIT10) begin
                        rxNine_reg <= bitVal;
                     end else if (rxIdx_reg != 4'h0) begin
                        rxShift_reg <= {bitVal, rxShift_reg[7:1]};
                     end
                  end
               end
            end
            default: begin
               rxState_reg <= USP_RX_IDLE;
            end
         endcase
      end
   end

endmodule // usp_engine

// Top: registers, rate generation, two engines
module usp_serial_port
   import usp_pkg::*;
(
   input  wire logic       clk,           // System clock, 100 MHz
   input  wire logic       rst,           // Asynchronous reset, active high
   input  wire logic [3:0] regAddr,       // Register index
   input  wire logic [7:0] regWrData,     // Write data
   input  wire logic       regWr,         // Write strobe
   input  wire logic       regRd,         // Read strobe
   output logic [7:0]      regRdData,     // Read data, cycle after strobe
   input  wire logic       baudTick,      // baud_timer overflow, first port
   input  wire logic       baudTick2,     // Rate timer overflow, second port
   input  wire logic       rxd1,          // First port serial input pin
   output logic            txd1,          // First port serial output
   input  wire logic       rxd2,          // Second port serial input pin
   output logic            txd2,          // Second port serial output
   output logic            shiftClkTick   // Shift-mode rate pulse
);
   import usp_pkg::*;

   logic [7:0] ctrl1_reg;
   logic [7:0] mode1_reg;
   logic [7:0] rxBuf1_reg;
   logic [7:0] slave_address_reg;
   logic [7:0] smask_reg;
   logic [7:0] ctrl2_reg;
   logic [7:0] mode2_reg;
   logic [7:0] rxBuf2_reg;
   logic [3:0] rateCnt_reg;
   logic [1:0] rxd1Sync_reg;
   logic [1:0] rxd2Sync_reg;
   logic       fixTick_reg;

   logic       txDone1;
   logic       rxLoad1;
   logic       rxDone1;
   logic [7:0] rxData1;
   logic       rxNinth1;
   logic       txDone2;
   logic       rxLoad2;
   logic       rxDone2;
   logic [7:0] rxData2;
   logic       rxNinth2;

   // Register write decode
   wire wrCtrl1 = regWr && (regAddr == ADDR_CTRL1);
   wire wrMode1 = regWr && (regAddr == ADDR_MODE1);
   wire wrBuf1  = regWr && (regAddr == ADDR_BUF1);
   wire wrSaddr = regWr && (regAddr == ADDR_SLAVE_ADDRESS);
   wire wrSmask = regWr && (regAddr == ADDR_SMASK);
   wire wrCtrl2 = regWr && (regAddr == ADDR_CTRL2);
   wire wrMode2 = regWr && (regAddr == ADDR_MODE2);
   wire wrBuf2  = regWr && (regAddr == ADDR_BUF2);

   // Mode decode for the first port
   usp_mode_t mode1;
   assign mode1 = usp_mode_t'({mode1_reg[MODE_SEL_HIGH], mode1_reg[MODE_SEL_LOW]});
   wire async1   = mode1 != USP_MODE_SHIFT;
   wire nine1    = (mode1 == USP_MODE_UART9F) || (mode1 == USP_MODE_UART9V);
   wire fixed1   = mode1 == USP_MODE_UART9F;
   wire [3:0] rateLim = fixed1
      ? (mode1_reg[MODE_BAUD_DOUBLE] ? LIM_FIX_FAST : LIM_FIX_SLOW)
      : (mode1_reg[MODE_SHIFT_FAST]  ? LIM_SH_FAST  : LIM_SH_SLOW);
   wire rateHit  = rateCnt_reg >= rateLim;
   wire tick1    = fixed1 ? fixTick_reg : baudTick;

   // Shared rate divider for fixed and shift modes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rateCnt_reg  <= 4'h0;
         fixTick_reg  <= 1'b0;
         shiftClkTick <= 1'b0;
      end else begin
         rateCnt_reg  <= rateHit ? 4'h0 : rateCnt_reg + 4'h1;
         fixTick_reg  <= rateHit && fixed1;
         shiftClkTick <= rateHit && (mode1 == USP_MODE_SHIFT);
      end
   end

   // Pin synchronisers; only the second stage is used
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxd1Sync_reg <= 2'b11;
         rxd2Sync_reg <= 2'b11;
      end else begin
         rxd1Sync_reg <= {rxd1Sync_reg[0], rxd1};
         rxd2Sync_reg <= {rxd2Sync_reg[0], rxd2};
      end
   end

   // Flag update: hardware set wins over a software clear of zero
   function automatic logic [7:0] ctrlNext(input logic [7:0] cur, input logic wr,
                                           input logic [7:0] wd, input logic tiSet,
                                           input logic riSet, input logic ld,
                                           input logic ninth);
      logic [7:0] n;
      n = cur;
      if (wr) begin
         n = (cur & ~CTL_RW_MASK) | (wd & CTL_RW_MASK);
         n[CTL_TX_DONE] = cur[CTL_TX_DONE] & wd[CTL_TX_DONE];
         n[CTL_RX_DONE] = cur[CTL_RX_DONE] & wd[CTL_RX_DONE];
      end
      if (ld) begin
         n[CTL_RX_NINE] = ninth;
      end
      n[CTL_TX_DONE] = n[CTL_TX_DONE] | tiSet;
      n[CTL_RX_DONE] = n[CTL_RX_DONE] | riSet;
      ctrlNext = n;
   endfunction

   wire [7:0] ctrl1_next = ctrlNext(ctrl1_reg, wrCtrl1, regWrData, txDone1,
                                    rxDone1, rxLoad1, rxNinth1);
   wire [7:0] ctrl2_next = ctrlNext(ctrl2_reg, wrCtrl2, regWrData, txDone2,
                                    rxDone2, rxLoad2, rxNinth2);

   // Register storage; reserved bits never take write data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl1_reg  <= RESET_BYTE;
         mode1_reg  <= RESET_BYTE;
         rxBuf1_reg <= RESET_BYTE;
         slave_address_reg  <= RESET_BYTE;
         smask_reg  <= RESET_BYTE;
         ctrl2_reg  <= RESET_BYTE;
         mode2_reg  <= RESET_BYTE;
         rxBuf2_reg <= RESET_BYTE;
      end else begin
         ctrl1_reg <= ctrl1_next;
         ctrl2_reg <= ctrl2_next;
         if (wrMode1) begin
            mode1_reg <= regWrData & MODE1_RW_MASK;
         end
         if (wrMode2) begin
            mode2_reg <= regWrData & MODE2_RW_MASK;
         end
         if (wrSaddr) begin
            slave_address_reg <= regWrData;
         end
         if (wrSmask) begin
            smask_reg <= regWrData;
         end
         if (rxLoad1) begin
            rxBuf1_reg <= rxData1;
         end
         if (rxLoad2) begin
            rxBuf2_reg <= rxData2;
         end
      end
   end

   // Read mux; unmapped indices read zero
   logic [7:0] rdMux;
   always_comb begin
      case (regAddr)
         ADDR_CTRL1: rdMux = ctrl1_reg;
         ADDR_MODE1: rdMux = mode1_reg;
         ADDR_BUF1:  rdMux = rxBuf1_reg;
         ADDR_SLAVE_ADDRESS: rdMux = slave_address_reg;
         ADDR_SMASK: rdMux = smask_reg;
         ADDR_CTRL2: rdMux = ctrl2_reg;
         ADDR_MODE2: rdMux = mode2_reg;
         ADDR_BUF2:  rdMux = rxBuf2_reg;
         default:    rdMux = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= regRd ? rdMux : 8'h00;
      end
   end

   // First port engine: address recognition in nine-bit modes
   usp_engine u_port1 (
      .clk       (clk),
      .rst       (rst),
      .tick16    (tick1),
      .active    (async1),
      .nineBit   (nine1),
      .checkBit  (mode1_reg[MODE_MP_CHECK]),
      .useAddr   (1'b1),
      .rxEnable  (ctrl1_reg[CTL_RX_EN]),
      .rxdSync   (rxd1Sync_reg[1]),
      .riFlag    (ctrl1_reg[CTL_RX_DONE]),
      .addrVal   (slave_address_reg),
      .addrMask  (smask_reg),
      .txLoad    (wrBuf1),
      .txData    (regWrData),
      .txNinth   (ctrl1_reg[CTL_TX_NINE]),
      .txd       (txd1),
      .txDoneSet (txDone1),
      .rxLoad    (rxLoad1),
      .rxDoneSet (rxDone1),
      .rxData    (rxData1),
      .rxNinth   (rxNinth1)
   );

   // Second port engine: two modes, no hardware address match
   usp_engine u_port2 (
      .clk       (clk),
      .rst       (rst),
      .tick16    (baudTick2),
      .active    (1'b1),
      .nineBit   (mode2_reg[MODE2_NINE]),
      .checkBit  (mode2_reg[MODE_MP_CHECK]),
      .useAddr   (1'b0),
      .rxEnable  (ctrl2_reg[CTL_RX_EN]),
      .rxdSync   (rxd2Sync_reg[1]),
      .riFlag    (ctrl2_reg[CTL_RX_DONE]),
      .addrVal   (8'h00),
      .addrMask  (8'h00),
      .txLoad    (wrBuf2),
      .txData    (regWrData),
      .txNinth   (ctrl2_reg[CTL_TX_NINE]),
      .txd       (txd2),
      .txDoneSet (txDone2),
      .rxLoad    (rxLoad2),
      .rxDoneSet (rxDone2),
      .rxData    (rxData2),
      .rxNinth   (rxNinth2)
   );

endmodule // usp_serial_port

// File: src/usp_pkg.sv
// Constants shared by the serial port block: register map, fields, resets, dividers
package usp_pkg;

   // Register indices on the plain register port (byte address = index)
   localparam logic [3:0] ADDR_CTRL1  = 4'h0;  // First port control and flags
   localparam logic [3:0] ADDR_MODE1  = 4'h1;  // serial_mode_control
   localparam logic [3:0] ADDR_BUF1   = 4'h2;  // serial_data_buffer
   localparam logic [3:0] ADDR_SLAVE_ADDRESS  = 4'h3;  // slave_address
   localparam logic [3:0] ADDR_SMASK  = 4'h4;  // slave_address_mask
   localparam logic [3:0] ADDR_CTRL2  = 4'h5;  // Second port control and flags
   localparam logic [3:0] ADDR_MODE2  = 4'h6;  // Second port mode
   localparam logic [3:0] ADDR_BUF2   = 4'h7;  // second_port_buffer

   // Control register fields, same for both ports
   localparam int CTL_RX_EN   = 4;
   localparam int CTL_TX_NINE = 3;
   localparam int CTL_RX_NINE = 2;
   localparam int CTL_TX_DONE = 1;
   localparam int CTL_RX_DONE = 0;
   localparam logic [7:0] CTL_RW_MASK = 8'h18;  // Writable plain bits

   // serial_mode_control fields
   localparam int MODE_BAUD_DOUBLE = 7;
   localparam int MODE_SHIFT_FAST  = 5;
   localparam int MODE_SEL_HIGH    = 2;
   localparam int MODE_SEL_LOW     = 1;
   localparam int MODE_MP_CHECK    = 0;
   localparam logic [7:0] MODE1_RW_MASK = 8'ha7;  // Reserved bits stay zero
   localparam logic [7:0] MODE2_RW_MASK = 8'h03;  // Nine-bit select and check bit
   localparam int MODE2_NINE = 1;

   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // Mode field encodings
   typedef enum logic [1:0] {
      USP_MODE_SHIFT  = 2'h0,
      USP_MODE_UART8  = 2'h1,
      USP_MODE_UART9F = 2'h2,
      USP_MODE_UART9V = 2'h3
   } usp_mode_t;

   // Fixed-rate dividers, in system clocks per bit (fixed modes) or per shift tick
   localparam int FIXED_DIV_SLOW  = 64;   // Nine-bit fixed, baud_double clear
   localparam int FIXED_DIV_FAST  = 32;   // Nine-bit fixed, baud_double set
   localparam int SHIFT_DIV_SLOW  = 12;   // Shift mode, shift_clock_fast clear
   localparam int SHIFT_DIV_FAST  = 2;    // Shift mode, shift_clock_fast set
   localparam int OVERSAMPLE      = 16;
   localparam logic [3:0] LIM_FIX_SLOW = 4'(FIXED_DIV_SLOW / OVERSAMPLE - 1);
   localparam logic [3:0] LIM_FIX_FAST = 4'(FIXED_DIV_FAST / OVERSAMPLE - 1);
   localparam logic [3:0] LIM_SH_SLOW  = 4'(SHIFT_DIV_SLOW - 1);
   localparam logic [3:0] LIM_SH_FAST  = 4'(SHIFT_DIV_FAST - 1);

   // Bit timing inside one bit of sixteen states
   localparam logic [3:0] SAMPLE_A  = 4'h7;
   localparam logic [3:0] SAMPLE_B  = 4'h8;
   localparam logic [3:0] SAMPLE_C  = 4'h9;
   localparam logic [3:0] LAST_STATE = 4'hf;
   localparam logic [3:0] LAST_BIT10 = 4'h9;   // Stop bit index, ten-bit frame
   localparam logic [3:0] LAST_BIT11 = 4'ha;   // Stop bit index, eleven-bit frame

   // Receiver states
   typedef enum logic [1:0] {
      USP_RX_IDLE = 2'b01,
      USP_RX_BUSY = 2'b10
   } usp_rx_state_t;

endpackage

// File: bench/usp_checker.sv
// Checker: port-level properties of the serial port block
`timescale 1ns/1ps
module usp_checker (
   input wire logic       clk,          // System clock
   input wire logic       rst,          // Asynchronous reset
   input wire logic [3:0] regAddr,      // Register index
   input wire logic [7:0] regWrData,    // Write data
   input wire logic       regWr,        // Write strobe
   input wire logic       regRd,        // Read strobe
   input wire logic [7:0] regRdData,    // Read data
   input wire logic       baudTick2,    // Second port tick
   input wire logic       txd2,         // Second port output
   input wire logic       shiftClkTick  // Shift-mode pulse
);
   import usp_pkg::*;
   logic [3:0] txCnt;   // Free count of second-port ticks
   logic [1:0] modeSh;  // Shadow of the first-port mode field
   // Divider phase and mode shadow, both rebuilt from the ports
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txCnt  <= 4'h0;
         modeSh <= 2'h0;
      end else begin
         txCnt <= txCnt + 4'(baudTick2);
         if (regWr && regAddr == ADDR_MODE1) begin
            modeSh <= regWrData[2:1];
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 8'h00)
      else $error("read data not zero outside read cycle");
   a_unmapped_zero: assert property ($past(regRd) && $past(regAddr) > 4'h7 |-> regRdData == 8'h00)
      else $error("unmapped index read not zero");
   a_mode1_reserved: assert property ($past(regRd) && $past(regAddr) == ADDR_MODE1
      |-> (regRdData & ~MODE1_RW_MASK) == 8'h00) else $error("mode reserved bit set");
   a_mode2_reserved: assert property ($past(regRd) && $past(regAddr) == ADDR_MODE2
      |-> (regRdData & ~MODE2_RW_MASK) == 8'h00) else $error("mode2 reserved bit set");
   a_tx_on_roll: assert property ($changed(txd2) |-> txCnt == 4'h0)
      else $error("serial output moved off the divider rollover");
   a_start_low: assert property ($fell(txd2) |-> !txd2 [*8])
      else $error("start bit too short");
   a_shift_gap: assert property (shiftClkTick |=> !shiftClkTick)
      else $error("shift pulses too close");
   a_shift_mode_only: assert property (shiftClkTick
      |-> $past(modeSh) == 2'h0 || $past(modeSh, 2) == 2'h0) else $error("shift pulse outside mode");
endmodule // usp_checker

bind usp_serial_port usp_checker usp_checker_i (.clk(clk), .rst(rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .baudTick2(baudTick2), .txd2(txd2), .shiftClkTick(shiftClkTick));

// File: bench/usp_far_node.sv
// Far serial node: sends frames to the port and decodes its output
`timescale 1ns/1ps
module usp_far_node #(
   parameter int BIT = 32   // Clocks per bit
) (
   input  wire logic clk,     // System clock
   input  wire logic rxLine,  // From the port's serial output
   output logic      txLine   // To the port's serial input, idle high
);
   initial txLine = 1'b1;
   // Frame out LSB first; a trailing idle bit keeps the next start edge clean
   task automatic send(input logic [10:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         txLine <= bits[i];
         repeat (BIT - 1) @(posedge clk);
      end
      @(posedge clk);
      txLine <= 1'b1;
      repeat (BIT - 1) @(posedge clk);
   endtask
   // Low pulse of four clocks, over well before the first vote sample
   task automatic glitch();
      @(posedge clk);
      txLine <= 1'b0;
      repeat (4) @(posedge clk);
      txLine <= 1'b1;
   endtask
   // Sample each bit in its middle
   task automatic recv(output logic [10:0] bits, input int n);
      bits = 11'h000;
      @(negedge rxLine);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         bits[i] = rxLine;
         repeat (BIT) @(posedge clk);
      end
   endtask
endmodule // usp_far_node

// File: bench/usp_serial_port_test.sv
// Testbench: register sequences and serial traffic on the second port
`timescale 1ns/1ps
module usp_serial_port_test;
   import usp_pkg::*;
   localparam int BIT = 32;  // Tick every 2 clocks, 16 ticks a bit
   logic        clk       = 1'b0;
   logic        rst       = 1'b1;
   logic [3:0]  regAddr   = 4'h0;
   logic [7:0]  regWrData = 8'h00;
   logic        regWr     = 1'b0;
   logic        regRd     = 1'b0;
   logic        baudTick  = 1'b0;
   logic        baudTick2 = 1'b0;
   logic [7:0]  regRdData;
   logic        rxd2, txd1, txd2, shiftClkTick;
   logic [10:0] fr;
   int          failures    = 0;
   int          check_count = 0;
   int          n;

   usp_serial_port usp_serial_port_i (.clk(clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .baudTick(baudTick), .baudTick2(baudTick2), .rxd1(rxd2), .txd1(txd1),
      .rxd2(rxd2), .txd2(txd2), .shiftClkTick(shiftClkTick));
   usp_far_node #(.BIT(BIT)) usp_far_node_i (.clk(clk), .rxLine(txd2), .txLine(rxd2));

   // 100 MHz clock
   initial forever #5 clk = ~clk;
   // Timer overflows as one-cycle pulses every other clock
   always @(posedge clk) begin
      baudTick  <= ~baudTick;
      baudTick2 <= ~baudTick2;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdData, e);
   endtask
   task automatic pulses(input logic [7:0] e);
      n = 0;
      repeat (20) @(posedge clk);
      repeat (120) begin
         @(posedge clk);
         #1 n += int'(shiftClkTick);
      end
      chk(8'(n), e);
   endtask
   task automatic snd(input logic [7:0] d, input logic b9, input logic b10, input int k);
      usp_far_node_i.send({b10, b9, d, 1'b0}, k);
   endtask
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Watchdog well beyond the roughly 5k clocks the tests need
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      finish_test();
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) rdc(4'(a), 8'h00);
      rdc(4'hc, 8'h00);
      $display("test 1 done: reset values");
      wr(ADDR_MODE1, 8'hff);
      rdc(ADDR_MODE1, 8'ha7);
      wr(ADDR_MODE2, 8'hff);
      rdc(ADDR_MODE2, 8'h03);
      wr(ADDR_SLAVE_ADDRESS, 8'ha5);
      rdc(ADDR_SLAVE_ADDRESS, 8'ha5);
      wr(ADDR_SMASK, 8'h5a);
      rdc(ADDR_SMASK, 8'h5a);
      wr(4'h9, 8'hff);
      rdc(4'h9, 8'h00);
      $display("test 2 done: access kinds");
      wr(ADDR_MODE1, 8'h00);
      pulses(8'd10);
      wr(ADDR_MODE1, 8'h20);
      pulses(8'd60);
      wr(ADDR_MODE1, 8'h02);
      pulses(8'd0);
      $display("test 3 done: shift rate");
      wr(ADDR_MODE2, 8'h00);
      wr(ADDR_CTRL2, 8'h00);
      fork
         usp_far_node_i.recv(fr, 10);
         wr(ADDR_BUF2, 8'h5a);
      join
      chk(fr[8:1], 8'h5a);
      chk({6'h00, fr[9], fr[0]}, 8'h02);
      rdc(ADDR_CTRL2, 8'h02);
      repeat (2 * BIT) @(posedge clk);
      wr(ADDR_MODE2, 8'h02);
      wr(ADDR_CTRL2, 8'h08);
      rdc(ADDR_CTRL2, 8'h08);
      fork
         usp_far_node_i.recv(fr, 11);
         wr(ADDR_BUF2, 8'hc3);
      join
      chk(fr[8:1], 8'hc3);
      chk({5'h00, fr[10:9], fr[0]}, 8'h06);
      rdc(ADDR_CTRL2, 8'h0a);
      $display("test 4 done: transmit");
      repeat (2 * BIT) @(posedge clk);
      wr(ADDR_MODE2, 8'h00);
      wr(ADDR_CTRL2, 8'h00);
      snd(8'h11, 1'b1, 1'b1, 10);
      rdc(ADDR_CTRL2, 8'h00);
      wr(ADDR_CTRL2, 8'h10);
      usp_far_node_i.glitch();
      repeat (2 * BIT) @(posedge clk);
      rdc(ADDR_CTRL2, 8'h10);
      snd(8'h3c, 1'b1, 1'b1, 10);
      rdc(ADDR_CTRL2, 8'h15);
      rdc(ADDR_BUF2, 8'h3c);
      snd(8'h77, 1'b1, 1'b1, 10);
      rdc(ADDR_BUF2, 8'h3c);
      wr(ADDR_CTRL2, 8'h13);
      rdc(ADDR_CTRL2, 8'h15);
      wr(ADDR_CTRL2, 8'h10);
      rdc(ADDR_CTRL2, 8'h14);
      $display("test 5 done: ten-bit receive");
      wr(ADDR_MODE2, 8'h01);
      snd(8'h42, 1'b0, 1'b1, 10);
      rdc(ADDR_CTRL2, 8'h14);
      snd(8'h42, 1'b1, 1'b1, 10);
      rdc(ADDR_CTRL2, 8'h15);
      rdc(ADDR_BUF2, 8'h42);
      wr(ADDR_CTRL2, 8'h10);
      $display("test 6 done: stop check");
      wr(ADDR_MODE1, 8'h07);
      wr(ADDR_CTRL1, 8'h10);
      wr(ADDR_MODE2, 8'h02);
      snd(8'h24, 1'b1, 1'b0, 11);
      rdc(ADDR_CTRL2, 8'h14);
      rdc(ADDR_BUF2, 8'h24);
      wr(ADDR_MODE2, 8'h03);
      snd(8'hc3, 1'b0, 1'b1, 11);
      rdc(ADDR_CTRL2, 8'h14);
      snd(8'hc3, 1'b1, 1'b1, 11);
      rdc(ADDR_CTRL2, 8'h15);
      rdc(ADDR_BUF2, 8'hc3);
      rdc(ADDR_CTRL1, 8'h10);
      snd(8'h24, 1'b1, 1'b1, 11);
      rdc(ADDR_CTRL1, 8'h15);
      rdc(ADDR_BUF1, 8'h24);
      $display("test 7 done: nine-bit receive");
      finish_test();
   end
endmodule // usp_serial_port_test
